//--- core/pcrs_defs.svh
// Constants of the program counter and return stack block
`ifndef PCRS_DEFS_SVH
`define PCRS_DEFS_SVH

// ****************************************
// Widths and reset values
// ****************************************
`define PCRS_PC_W 15
`define PCRS_SP_W 5
`define PCRS_DEPTH 16
`define PCRS_ADDR_W 14
`define PCRS_PC_RESET 15'h0000
`define PCRS_SP_EMPTY 5'h1f
`define PCRS_SP_TOP 5'h0f
`define PCRS_SP_AFTER_UNDERFLOW 5'h0e
`define PCRS_INT_VECTOR 15'h0004

// ****************************************
// Register indices, byte address is four times the index
// ****************************************
`define PCRS_IDX_COUNTER_LOW 12'hfe0
`define PCRS_IDX_HIGH_LATCH 12'hfe1
`define PCRS_IDX_STATUS_SHAD 12'hfe4
`define PCRS_IDX_WORKING_REG_SHADOW 12'hfe5
`define PCRS_IDX_BANK_SHAD 12'hfe6
`define PCRS_IDX_LATCH_SHAD 12'hfe7
`define PCRS_IDX_PTR0L_SHAD 12'hfe8
`define PCRS_IDX_PTR0H_SHAD 12'hfe9
`define PCRS_IDX_PTR1L_SHAD 12'hfea
`define PCRS_IDX_PTR1H_SHAD 12'hfeb
`define PCRS_IDX_STACK_PTR 12'hfed
`define PCRS_IDX_TOS_LOW 12'hfee
`define PCRS_IDX_TOS_HIGH 12'hfef
`define PCRS_IDX_PC_READ 12'hff0
`define PCRS_IDX_IRQ_STATUS 12'hff1
`define PCRS_IDX_IRQ_MASK 12'hff2

// ****************************************
// Interrupt bit positions and bus answers
// ****************************************
`define PCRS_IRQ_OVF 0
`define PCRS_IRQ_UNF 1
`define PCRS_RESP_OKAY 2'b00
`define PCRS_RESP_SLVERR 2'b10

`endif

//--- core/pcrs_pkg.sv
// Types of the program counter and return stack block
package pcrs_pkg;

  // ****************************************
  // Core commands
  // ****************************************
  typedef enum logic [3:0] {
    OP_NONE = 4'h0,
    OP_INCR = 4'h1,
    OP_WRITE_LOW = 4'h2,
    OP_WRITE_LATCH = 4'h3,
    OP_CALL_ABS = 4'h4,
    OP_CALL_W = 4'h5,
    OP_BRANCH_W = 4'h6,
    OP_BRANCH_REL = 4'h7,
    OP_RETURN = 4'h8,
    OP_RETURN_LIT = 4'h9,
    OP_RETURN_INT = 4'ha,
    OP_INT_ENTRY = 4'hb
  } pcrs_op_type;

  typedef struct packed {
    pcrs_op_type op;
    logic [10:0] operand;
    logic [7:0] data;
  } pcrs_cmd_type;

  // Core context saved on interrupt entry
  typedef struct packed {
    logic [2:0] status;
    logic [7:0] wreg;
    logic [4:0] bank;
    logic [7:0] ptr0_low;
    logic [7:0] ptr0_high;
    logic [7:0] ptr1_low;
    logic [7:0] ptr1_high;
  } pcrs_context_type;

  // ****************************************
  // Register selection
  // ****************************************
  typedef enum logic [3:0] {
    SEL_NONE = 4'h0,
    SEL_COUNTER_LOW = 4'h1,
    SEL_HIGH_LATCH = 4'h2,
    SEL_STATUS_SHAD = 4'h3,
    SEL_WORKING_REG_SHADOW = 4'h4,
    SEL_BANK_SHAD = 4'h5,
    SEL_LATCH_SHAD = 4'h6,
    SEL_PTR0L_SHAD = 4'h7,
    SEL_PTR0H_SHAD = 4'h8,
    SEL_PTR1L_SHAD = 4'h9,
    SEL_PTR1H_SHAD = 4'ha,
    SEL_STACK_PTR = 4'hb,
    SEL_TOS_LOW = 4'hc,
    SEL_TOS_HIGH = 4'hd,
    SEL_PC_READ = 4'he,
    SEL_IRQ_STATUS = 4'hf
  } pcrs_sel_type;

endpackage

//--- core/pcrs_top.sv
// Program counter sequencing and hardware return stack with AXI4-Lite register access
//
// The implementer's own choice: the AXI4-Lite interface to the registers.
`include "pcrs_defs.svh"

module pcrs_top (
  // Clock and reset
  input wire logic SYS_CLK_I,
  input wire logic RST_I,
  // Core command and context
  input wire pcrs_pkg::pcrs_cmd_type CMD_I,
  input wire pcrs_pkg::pcrs_context_type CONTEXT_I,
  input wire logic STACK_FAULT_RESET_OPTION_I,
  // Core results
  output logic [14:0] PC_O,
  output logic [6:0] HIGH_LATCH_O,
  output logic [4:0] STACK_PTR_O,
  output pcrs_pkg::pcrs_context_type CONTEXT_O,
  output logic RESTORE_O,
  output logic DEVICE_RESET_O,
  output logic IRQ_O,
  // AXI4-Lite write channels
  input wire logic [13:0] S_AXI_AWADDR_I,
  input wire logic S_AXI_AWVALID_I,
  output logic S_AXI_AWREADY_O,
  input wire logic [31:0] S_AXI_WDATA_I,
  input wire logic [3:0] S_AXI_WSTRB_I,
  input wire logic S_AXI_WVALID_I,
  output logic S_AXI_WREADY_O,
  output logic [1:0] S_AXI_BRESP_O,
  output logic S_AXI_BVALID_O,
  input wire logic S_AXI_BREADY_I,
  // AXI4-Lite read channels
  input wire logic [13:0] S_AXI_ARADDR_I,
  input wire logic S_AXI_ARVALID_I,
  output logic S_AXI_ARREADY_O,
  output logic [31:0] S_AXI_RDATA_O,
  output logic [1:0] S_AXI_RRESP_O,
  output logic S_AXI_RVALID_O,
  input wire logic S_AXI_RREADY_I
);

  // ****************************************
  // Functions
  // ****************************************
  function automatic pcrs_pkg::pcrs_sel_type decode(input logic [13:0] addr);
    logic [11:0] idx;
    idx = (addr[13:12] == 2'b11) ? addr[13:2] : 12'h000;
    case (idx)
      `PCRS_IDX_COUNTER_LOW: decode = pcrs_pkg::SEL_COUNTER_LOW;
      `PCRS_IDX_HIGH_LATCH: decode = pcrs_pkg::SEL_HIGH_LATCH;
      `PCRS_IDX_STATUS_SHAD: decode = pcrs_pkg::SEL_STATUS_SHAD;
      `PCRS_IDX_WORKING_REG_SHADOW: decode = pcrs_pkg::SEL_WORKING_REG_SHADOW;
      `PCRS_IDX_BANK_SHAD: decode = pcrs_pkg::SEL_BANK_SHAD;
      `PCRS_IDX_LATCH_SHAD: decode = pcrs_pkg::SEL_LATCH_SHAD;
      `PCRS_IDX_PTR0L_SHAD: decode = pcrs_pkg::SEL_PTR0L_SHAD;
      `PCRS_IDX_PTR0H_SHAD: decode = pcrs_pkg::SEL_PTR0H_SHAD;
      `PCRS_IDX_PTR1L_SHAD: decode = pcrs_pkg::SEL_PTR1L_SHAD;
      `PCRS_IDX_PTR1H_SHAD: decode = pcrs_pkg::SEL_PTR1H_SHAD;
      `PCRS_IDX_STACK_PTR: decode = pcrs_pkg::SEL_STACK_PTR;
      `PCRS_IDX_TOS_LOW: decode = pcrs_pkg::SEL_TOS_LOW;
      `PCRS_IDX_TOS_HIGH: decode = pcrs_pkg::SEL_TOS_HIGH;
      `PCRS_IDX_PC_READ: decode = pcrs_pkg::SEL_PC_READ;
      `PCRS_IDX_IRQ_STATUS: decode = pcrs_pkg::SEL_IRQ_STATUS;
      default: decode = pcrs_pkg::SEL_NONE;
    endcase
  endfunction

  // Counter plus one plus offset, wraps in fifteen bits
  function automatic logic [14:0] advance(input logic [14:0] pc, input logic [14:0] offset);
    advance = 15'(pc + 15'h0001 + offset);
  endfunction

  // ****************************************
  // Declarations
  // ****************************************
  logic [14:0] pc_reg;
  logic [6:0] latch_reg;
  logic [4:0] sp_reg;
  logic [14:0] stack_mem [0:`PCRS_DEPTH-1];
  pcrs_pkg::pcrs_context_type shadow_reg;
  logic [6:0] latch_shadow_reg;
  logic [1:0] irq_status_reg;
  logic [1:0] irq_mask_reg;
  logic opt_meta_reg;
  logic opt_sync_reg;
  logic aw_ready_reg;
  logic b_valid_reg;
  logic [1:0] b_resp_reg;
  logic ar_ready_reg;
  logic r_valid_reg;
  logic [1:0] r_resp_reg;
  logic [31:0] r_data_reg;
  logic restore_reg;
  logic dev_reset_reg;
  logic irq_reg;
  pcrs_pkg::pcrs_context_type context_out_reg;

  logic wr_fire;
  logic rd_fire;
  pcrs_pkg::pcrs_sel_type wr_sel;
  pcrs_pkg::pcrs_sel_type rd_sel;
  logic [7:0] wr_byte;
  logic is_push;
  logic is_pop;
  logic overflow;
  logic underflow;
  logic fault_reset;
  logic [14:0] push_value;
  logic [4:0] sp_next;
  logic [3:0] push_slot;
  logic [14:0] pop_value;
  logic [14:0] pc_next;
  logic [14:0] tos_value;

  // ****************************************
  // Option pin synchroniser
  // ****************************************
  always_ff @(posedge SYS_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      opt_meta_reg <= 1'b0;
      opt_sync_reg <= 1'b0;
    end else begin
      opt_meta_reg <= STACK_FAULT_RESET_OPTION_I;
      opt_sync_reg <= opt_meta_reg;
    end
  end

  // ****************************************
  // Bus handshakes
  // ****************************************
  assign wr_fire = aw_ready_reg & S_AXI_AWVALID_I & S_AXI_WVALID_I;
  assign rd_fire = ar_ready_reg & S_AXI_ARVALID_I;
  assign wr_sel = decode(S_AXI_AWADDR_I);
  assign rd_sel = decode(S_AXI_ARADDR_I);
  // Only the low lane carries data; a write without it stores nothing
  assign wr_byte = S_AXI_WDATA_I[7:0];

  // Address and data are taken together, one write at a time
  always_ff @(posedge SYS_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      aw_ready_reg <= 1'b0;
    end else begin
      aw_ready_reg <= ~aw_ready_reg & ~b_valid_reg & S_AXI_AWVALID_I & S_AXI_WVALID_I;
    end
  end

  always_ff @(posedge SYS_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      b_valid_reg <= 1'b0;
      b_resp_reg <= `PCRS_RESP_OKAY;
    end else if (wr_fire) begin
      b_valid_reg <= 1'b1;
      // Mask has no select code of its own, so it is matched by index
      b_resp_reg <= ((wr_sel == pcrs_pkg::SEL_NONE) && (S_AXI_AWADDR_I[13:2] != `PCRS_IDX_IRQ_MASK)) ?
                    `PCRS_RESP_SLVERR : `PCRS_RESP_OKAY;
    end else if (S_AXI_BREADY_I) begin
      b_valid_reg <= 1'b0;
    end
  end

  always_ff @(posedge SYS_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      ar_ready_reg <= 1'b0;
    end else begin
      ar_ready_reg <= ~ar_ready_reg & ~r_valid_reg & S_AXI_ARVALID_I;
    end
  end

  // ****************************************
  // Stack sequencing
  // ****************************************
  assign is_push = (CMD_I.op == pcrs_pkg::OP_CALL_ABS) | (CMD_I.op == pcrs_pkg::OP_CALL_W) |
                   (CMD_I.op == pcrs_pkg::OP_INT_ENTRY);
  assign is_pop = (CMD_I.op == pcrs_pkg::OP_RETURN) | (CMD_I.op == pcrs_pkg::OP_RETURN_LIT) |
                  (CMD_I.op == pcrs_pkg::OP_RETURN_INT);
  assign overflow = is_push & (sp_reg == `PCRS_SP_TOP);
  assign underflow = is_pop & (sp_reg == `PCRS_SP_EMPTY);
  assign fault_reset = opt_sync_reg & (overflow | underflow);
  // Interrupt entry saves the next instruction, calls save the one after
  assign push_value = (CMD_I.op == pcrs_pkg::OP_INT_ENTRY) ? pc_reg : advance(pc_reg, 15'h0000);
  // Pointer moves first, then the entry is written at the new slot
  assign sp_next = overflow ? 5'h00 : 5'(sp_reg + 5'h01);
  assign push_slot = sp_next[3:0];
  assign pop_value = stack_mem[sp_reg[3:0]];
  assign tos_value = stack_mem[sp_reg[3:0]];

  always_comb begin
    pc_next = pc_reg;
    case (CMD_I.op)
      pcrs_pkg::OP_INCR: pc_next = advance(pc_reg, 15'h0000);
      pcrs_pkg::OP_WRITE_LOW: pc_next = {latch_reg, CMD_I.data};
      pcrs_pkg::OP_CALL_ABS: pc_next = {latch_reg[6:3], CMD_I.operand};
      pcrs_pkg::OP_CALL_W: pc_next = {latch_reg, CMD_I.data};
      pcrs_pkg::OP_BRANCH_W: pc_next = advance(pc_reg, {7'h00, CMD_I.data});
      pcrs_pkg::OP_BRANCH_REL: pc_next = advance(pc_reg, {{6{CMD_I.operand[8]}}, CMD_I.operand[8:0]});
      pcrs_pkg::OP_RETURN: pc_next = pop_value;
      pcrs_pkg::OP_RETURN_LIT: pc_next = pop_value;
      pcrs_pkg::OP_RETURN_INT: pc_next = pop_value;
      pcrs_pkg::OP_INT_ENTRY: pc_next = `PCRS_INT_VECTOR;
      default: pc_next = pc_reg;
    endcase
  end

  // ****************************************
  // Program counter
  // ****************************************
  // A core command wins over a bus write in the same cycle
  always_ff @(posedge SYS_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      pc_reg <= `PCRS_PC_RESET;
    end else if (fault_reset) begin
      pc_reg <= `PCRS_PC_RESET;
    end else if (CMD_I.op != pcrs_pkg::OP_NONE) begin
      pc_reg <= pc_next;
    end else if (wr_fire & S_AXI_WSTRB_I[0] & (wr_sel == pcrs_pkg::SEL_COUNTER_LOW)) begin
      pc_reg <= {latch_reg, wr_byte};
    end
  end

  // Latch is not touched by stack traffic, except a return from interrupt, which reloads it from the latch shadow
  always_ff @(posedge SYS_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      latch_reg <= 7'h00;
    end else if (CMD_I.op == pcrs_pkg::OP_WRITE_LATCH) begin
      latch_reg <= CMD_I.data[6:0];
    end else if (CMD_I.op == pcrs_pkg::OP_RETURN_INT) begin
      latch_reg <= latch_shadow_reg;
    end else if (wr_fire & S_AXI_WSTRB_I[0] & (wr_sel == pcrs_pkg::SEL_HIGH_LATCH)) begin
      latch_reg <= wr_byte[6:0];
    end
  end

  // ****************************************
  // Stack pointer and entries
  // ****************************************
  always_ff @(posedge SYS_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      sp_reg <= `PCRS_SP_EMPTY;
    end else if (fault_reset) begin
      sp_reg <= `PCRS_SP_EMPTY;
    end else if (is_push) begin
      sp_reg <= sp_next;
    end else if (is_pop) begin
      sp_reg <= underflow ? `PCRS_SP_AFTER_UNDERFLOW : 5'(sp_reg - 5'h01);
    end else if (wr_fire & S_AXI_WSTRB_I[0] & (wr_sel == pcrs_pkg::SEL_STACK_PTR)) begin
      sp_reg <= wr_byte[4:0];
    end
  end

  // Entries carry no reset; they are storage, not control
  always_ff @(posedge SYS_CLK_I) begin
    if (is_push & ~fault_reset) begin
      stack_mem[push_slot] <= push_value;
    end else if (CMD_I.op == pcrs_pkg::OP_NONE && wr_fire && S_AXI_WSTRB_I[0]) begin
      if (wr_sel == pcrs_pkg::SEL_TOS_LOW) begin
        stack_mem[sp_reg[3:0]][7:0] <= wr_byte;
      end else if (wr_sel == pcrs_pkg::SEL_TOS_HIGH) begin
        stack_mem[sp_reg[3:0]][14:8] <= wr_byte[6:0];
      end
    end
  end

  // ****************************************
  // Shadow context
  // ****************************************
  always_ff @(posedge SYS_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      shadow_reg <= '0;
      latch_shadow_reg <= 7'h00;
    end else if (CMD_I.op == pcrs_pkg::OP_INT_ENTRY) begin
      shadow_reg <= CONTEXT_I;
      latch_shadow_reg <= latch_reg;
    end else if (wr_fire & S_AXI_WSTRB_I[0]) begin
      case (wr_sel)
        pcrs_pkg::SEL_STATUS_SHAD: shadow_reg.status <= wr_byte[2:0];
        pcrs_pkg::SEL_WORKING_REG_SHADOW: shadow_reg.wreg <= wr_byte;
        pcrs_pkg::SEL_BANK_SHAD: shadow_reg.bank <= wr_byte[4:0];
        pcrs_pkg::SEL_LATCH_SHAD: latch_shadow_reg <= wr_byte[6:0];
        pcrs_pkg::SEL_PTR0L_SHAD: shadow_reg.ptr0_low <= wr_byte;
        pcrs_pkg::SEL_PTR0H_SHAD: shadow_reg.ptr0_high <= wr_byte;
        pcrs_pkg::SEL_PTR1L_SHAD: shadow_reg.ptr1_low <= wr_byte;
        pcrs_pkg::SEL_PTR1H_SHAD: shadow_reg.ptr1_high <= wr_byte;
        default: shadow_reg <= shadow_reg;
      endcase
    end
  end

  always_ff @(posedge SYS_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      context_out_reg <= '0;
      restore_reg <= 1'b0;
    end else begin
      restore_reg <= (CMD_I.op == pcrs_pkg::OP_RETURN_INT);
      if (CMD_I.op == pcrs_pkg::OP_RETURN_INT) begin
        context_out_reg <= shadow_reg;
      end
    end
  end

  // ****************************************
  // Fault flags and interrupt
  // ****************************************
  // Hardware set beats a write-one-to-clear in the same cycle
  always_ff @(posedge SYS_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      irq_status_reg <= 2'b00;
    end else begin
      if (wr_fire & S_AXI_WSTRB_I[0] & (wr_sel == pcrs_pkg::SEL_IRQ_STATUS)) begin
        irq_status_reg <= (irq_status_reg & ~wr_byte[1:0]) | {underflow, overflow};
      end else begin
        irq_status_reg <= irq_status_reg | {underflow, overflow};
      end
    end
  end

  always_ff @(posedge SYS_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      irq_mask_reg <= 2'b00;
      irq_reg <= 1'b0;
      dev_reset_reg <= 1'b0;
    end else begin
      if (wr_fire & S_AXI_WSTRB_I[0] & (S_AXI_AWADDR_I[13:2] == `PCRS_IDX_IRQ_MASK)) begin
        irq_mask_reg <= wr_byte[1:0];
      end
      irq_reg <= |(irq_status_reg & irq_mask_reg);
      dev_reset_reg <= fault_reset;
    end
  end

  // ****************************************
  // Read data
  // ****************************************
  always_ff @(posedge SYS_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      r_valid_reg <= 1'b0;
      r_resp_reg <= `PCRS_RESP_OKAY;
      r_data_reg <= 32'h0000_0000;
    end else if (rd_fire) begin
      r_valid_reg <= 1'b1;
      r_resp_reg <= `PCRS_RESP_OKAY;
      case (rd_sel)
        pcrs_pkg::SEL_COUNTER_LOW: r_data_reg <= {24'h000000, pc_reg[7:0]};
        pcrs_pkg::SEL_HIGH_LATCH: r_data_reg <= {25'h0000000, latch_reg};
        pcrs_pkg::SEL_STATUS_SHAD: r_data_reg <= {29'h00000000, shadow_reg.status};
        pcrs_pkg::SEL_WORKING_REG_SHADOW: r_data_reg <= {24'h000000, shadow_reg.wreg};
        pcrs_pkg::SEL_BANK_SHAD: r_data_reg <= {27'h0000000, shadow_reg.bank};
        pcrs_pkg::SEL_LATCH_SHAD: r_data_reg <= {25'h0000000, latch_shadow_reg};
        pcrs_pkg::SEL_PTR0L_SHAD: r_data_reg <= {24'h000000, shadow_reg.ptr0_low};
        pcrs_pkg::SEL_PTR0H_SHAD: r_data_reg <= {24'h000000, shadow_reg.ptr0_high};
        pcrs_pkg::SEL_PTR1L_SHAD: r_data_reg <= {24'h000000, shadow_reg.ptr1_low};
        pcrs_pkg::SEL_PTR1H_SHAD: r_data_reg <= {24'h000000, shadow_reg.ptr1_high};
        pcrs_pkg::SEL_STACK_PTR: r_data_reg <= {27'h0000000, sp_reg};
        pcrs_pkg::SEL_TOS_LOW: r_data_reg <= {24'h000000, tos_value[7:0]};
        pcrs_pkg::SEL_TOS_HIGH: r_data_reg <= {25'h0000000, tos_value[14:8]};
        pcrs_pkg::SEL_PC_READ: r_data_reg <= {17'h00000, pc_reg};
        pcrs_pkg::SEL_IRQ_STATUS: r_data_reg <= {30'h00000000, irq_status_reg};
        default: begin
          if (S_AXI_ARADDR_I[13:2] == `PCRS_IDX_IRQ_MASK) begin
            r_data_reg <= {30'h00000000, irq_mask_reg};
          end else begin
            r_data_reg <= 32'h0000_0000;
            r_resp_reg <= `PCRS_RESP_SLVERR;
          end
        end
      endcase
    end else if (S_AXI_RREADY_I) begin
      r_valid_reg <= 1'b0;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign PC_O = pc_reg;
  assign HIGH_LATCH_O = latch_reg;
  assign STACK_PTR_O = sp_reg;
  assign CONTEXT_O = context_out_reg;
  assign RESTORE_O = restore_reg;
  assign DEVICE_RESET_O = dev_reset_reg;
  assign IRQ_O = irq_reg;
  assign S_AXI_AWREADY_O = aw_ready_reg;
  assign S_AXI_WREADY_O = aw_ready_reg;
  assign S_AXI_BVALID_O = b_valid_reg;
  assign S_AXI_BRESP_O = b_resp_reg;
  assign S_AXI_ARREADY_O = ar_ready_reg;
  assign S_AXI_RVALID_O = r_valid_reg;
  assign S_AXI_RRESP_O = r_resp_reg;
  assign S_AXI_RDATA_O = r_data_reg;

endmodule

//--- bench/pcrs_props.sv
// Port checks of the program counter and return stack
module pcrs_props (
  // Clock and reset
  input wire logic SYS_CLK_I,
  input wire logic RST_I,
  // Watched ports
  input wire pcrs_pkg::pcrs_cmd_type CMD_I,
  input wire logic STACK_FAULT_RESET_OPTION_I,
  input wire logic [14:0] PC_O,
  input wire logic [6:0] HIGH_LATCH_O,
  input wire logic [4:0] STACK_PTR_O,
  input wire logic DEVICE_RESET_O
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge SYS_CLK_I); endclocking
  default disable iff (RST_I);
  logic push_w;
  logic pop_w;
  assign push_w = CMD_I.op inside {pcrs_pkg::OP_CALL_ABS, pcrs_pkg::OP_CALL_W, pcrs_pkg::OP_INT_ENTRY};
  assign pop_w = CMD_I.op inside {pcrs_pkg::OP_RETURN, pcrs_pkg::OP_RETURN_LIT, pcrs_pkg::OP_RETURN_INT};
  // Option must have crossed the synchroniser first
  sequence opt_on;
    STACK_FAULT_RESET_OPTION_I [*4];
  endsequence
  sequence opt_off;
    !STACK_FAULT_RESET_OPTION_I [*4];
  endsequence
  sequence ovf_push;
    push_w && STACK_PTR_O == 5'h0f;
  endsequence
  a_reset_clear: assert property (
    $fell(RST_I) |-> PC_O == 15'h0 && STACK_PTR_O == 5'h1f) else $error("counter not cleared by reset");
  a_write_low: assert property (
    CMD_I.op == pcrs_pkg::OP_WRITE_LOW |=> PC_O == {$past(HIGH_LATCH_O), $past(CMD_I.data)})
    else $error("low byte write load wrong");
  a_call_abs: assert property (
    CMD_I.op == pcrs_pkg::OP_CALL_ABS && STACK_PTR_O != 5'h0f
    |=> PC_O == {$past(HIGH_LATCH_O[6:3]), $past(CMD_I.operand)}) else $error("absolute call target wrong");
  a_branch_w: assert property (
    CMD_I.op == pcrs_pkg::OP_BRANCH_W |=> PC_O == $past(PC_O) + 15'h1 + {7'h0, $past(CMD_I.data)})
    else $error("branch by working wrong");
  a_branch_rel: assert property (
    CMD_I.op == pcrs_pkg::OP_BRANCH_REL
    |=> PC_O == $past(PC_O) + 15'h1 + {{6{$past(CMD_I.operand[8])}}, $past(CMD_I.operand[8:0])})
    else $error("relative branch wrong");
  a_push_step: assert property (
    push_w && STACK_PTR_O != 5'h0f |=> STACK_PTR_O == $past(STACK_PTR_O) + 5'h1) else $error("push step wrong");
  a_pop_step: assert property (
    pop_w && STACK_PTR_O != 5'h1f |=> STACK_PTR_O == $past(STACK_PTR_O) - 5'h1) else $error("pop step wrong");
  a_latch_kept: assert property (
    push_w || CMD_I.op inside {pcrs_pkg::OP_RETURN, pcrs_pkg::OP_RETURN_LIT} |=> $stable(HIGH_LATCH_O))
    else $error("latch moved by stack");
  a_circular_wrap: assert property (
    opt_off ##0 ovf_push |=> STACK_PTR_O == 5'h00 && !DEVICE_RESET_O) else $error("no wrap on overflow");
  a_fault_reset: assert property (
    opt_on ##0 ovf_push |=> DEVICE_RESET_O && PC_O == 15'h0 && STACK_PTR_O == 5'h1f)
    else $error("no fault reset on overflow");
endmodule

bind pcrs_top pcrs_props chk_u (.SYS_CLK_I, .RST_I, .CMD_I, .STACK_FAULT_RESET_OPTION_I, .PC_O, .HIGH_LATCH_O,
  .STACK_PTR_O, .DEVICE_RESET_O);

//--- bench/pcrs_core_model.sv
// Behavioural model of the core execution logic
module pcrs_core_model (
  // Clock
  input wire logic clk_i,
  // Commands and context
  output pcrs_pkg::pcrs_cmd_type cmd_o,
  output pcrs_pkg::pcrs_context_type context_o,
  output logic option_o
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    cmd_o = '0;
    context_o = {3'h5, 8'ha7, 5'h13, 8'h01, 8'h02, 8'h03, 8'h04};
    option_o = 1'h0;
  end
  // One cycle per command, so a level never repeats
  task automatic issue(input pcrs_pkg::pcrs_op_type op, input logic [10:0] operand, input logic [7:0] data);
    @(posedge clk_i);
    cmd_o <= '{op, operand, data};
    @(posedge clk_i);
    cmd_o.op <= pcrs_pkg::OP_NONE;
    #1;
  endtask
  // Waits out the two-flop synchroniser
  task automatic set_option(input logic v);
    @(posedge clk_i);
    option_o <= v;
    repeat (4) @(posedge clk_i);
  endtask
endmodule

//--- bench/test_program_counter_and_return_stack.sv
// Self-checking bench of the program counter and return stack
module test_program_counter_and_return_stack;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'h0;
  logic rst = 1'h1;
  logic [13:0] awaddr = '0, araddr = '0;
  logic [31:0] wdata = '0;
  logic [3:0] wstrb = 4'hf;
  logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
  logic awready, wready, bvalid, arready, rvalid, restore, dev_rst, irq, opt;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  logic [14:0] pc;
  logic [6:0] latch;
  logic [4:0] sp;
  logic [3:0] hs;
  pcrs_pkg::pcrs_cmd_type cmd;
  pcrs_pkg::pcrs_context_type ctx_in, ctx_out;
  int mismatches = 0;
  int cmp_count = 0;
  assign hs = {rvalid, arready, bvalid, awready & wready};
  always #12.5 clk = ~clk;
  pcrs_core_model core_u (.clk_i(clk), .cmd_o(cmd), .context_o(ctx_in), .option_o(opt));
  pcrs_top dut_u (.SYS_CLK_I(clk), .RST_I(rst), .CMD_I(cmd), .CONTEXT_I(ctx_in), .STACK_FAULT_RESET_OPTION_I(opt),
    .PC_O(pc), .HIGH_LATCH_O(latch), .STACK_PTR_O(sp), .CONTEXT_O(ctx_out), .RESTORE_O(restore),
    .DEVICE_RESET_O(dev_rst), .IRQ_O(irq), .S_AXI_AWADDR_I(awaddr), .S_AXI_AWVALID_I(awvalid),
    .S_AXI_AWREADY_O(awready), .S_AXI_WDATA_I(wdata), .S_AXI_WSTRB_I(wstrb), .S_AXI_WVALID_I(wvalid),
    .S_AXI_WREADY_O(wready), .S_AXI_BRESP_O(bresp), .S_AXI_BVALID_O(bvalid), .S_AXI_BREADY_I(bready),
    .S_AXI_ARADDR_I(araddr), .S_AXI_ARVALID_I(arvalid), .S_AXI_ARREADY_O(arready), .S_AXI_RDATA_O(rdata),
    .S_AXI_RRESP_O(rresp), .S_AXI_RVALID_O(rvalid), .S_AXI_RREADY_I(rready));
  // ****
  // Tasks
  // ****
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH at %0t: saw %h, expected %h", $time, got, exp);
    end
  endtask
  task automatic final_report();
    $display("Comparisons %0d, mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  // Bounded wait on one handshake: 0 aw, 1 b, 2 ar, 3 r
  task automatic wait_for(input int which);
    int n;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (hs[which] !== 1'h1 && n < 64);
    if (hs[which] !== 1'h1) begin
      mismatches++;
      final_report();
    end
  endtask
  task automatic axi_wr(input logic [11:0] idx, input logic [31:0] d, input logic [1:0] resp);
    @(posedge clk);
    awaddr <= {idx, 2'h0};
    wdata <= d;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    wait_for(0);
    awvalid <= 1'h0;
    wvalid <= 1'h0;
    wait_for(1);
    bready <= 1'h0;
    chk(bresp, resp);
  endtask
  task automatic axi_rd(input logic [11:0] idx, input logic [31:0] exp, input logic [1:0] resp);
    @(posedge clk);
    araddr <= {idx, 2'h0};
    arvalid <= 1'h1;
    rready <= 1'h1;
    wait_for(2);
    arvalid <= 1'h0;
    wait_for(3);
    rready <= 1'h0;
    chk(rdata, exp);
    chk(rresp, resp);
  endtask
  // ****
  // Sequence
  // ****
  initial begin
    repeat (6) @(posedge clk);
    rst <= 1'h0;
    axi_rd(12'hfed, 32'h1f, 2'h0);
    axi_rd(12'hff0, 32'h0, 2'h0);
    axi_wr(12'hfe1, 32'h55, 2'h0);
    axi_wr(12'hfe0, 32'h3c, 2'h0);
    chk(pc, 15'h553c);
    axi_rd(12'hfe0, 32'h3c, 2'h0);
    axi_wr(12'hfe1, 32'h7a, 2'h0);
    wstrb <= 4'he;
    axi_wr(12'hfe1, 32'h11, 2'h0);
    wstrb <= 4'hf;
    chk(latch, 7'h7a);
    core_u.issue(pcrs_pkg::OP_CALL_ABS, 11'h123, 8'h0);
    chk(pc, 15'h7923);
    core_u.issue(pcrs_pkg::OP_CALL_W, 11'h0, 8'h44);
    chk(pc, 15'h7a44);
    chk({latch, sp}, {7'h7a, 5'h01});
    axi_rd(12'hfee, 32'h24, 2'h0);
    axi_rd(12'hfef, 32'h79, 2'h0);
    core_u.issue(pcrs_pkg::OP_RETURN, 11'h0, 8'h0);
    chk({pc, sp}, {15'h7924, 5'h00});
    core_u.issue(pcrs_pkg::OP_RETURN_LIT, 11'h0, 8'h0);
    chk({pc, sp}, {15'h553d, 5'h1f});
    core_u.issue(pcrs_pkg::OP_BRANCH_W, 11'h0, 8'hff);
    chk(pc, 15'h563d);
    core_u.issue(pcrs_pkg::OP_BRANCH_REL, 11'h100, 8'h0);
    chk(pc, 15'h553e);
    core_u.issue(pcrs_pkg::OP_INCR, 11'h0, 8'h0);
    chk(pc, 15'h553f);
    core_u.issue(pcrs_pkg::OP_WRITE_LATCH, 11'h0, 8'h2b);
    core_u.issue(pcrs_pkg::OP_WRITE_LOW, 11'h0, 8'h9c);
    chk({latch, pc}, {7'h2b, 15'h2b9c});
    core_u.issue(pcrs_pkg::OP_WRITE_LATCH, 11'h0, 8'h7a);
    axi_wr(12'hfed, 32'h3, 2'h0);
    axi_wr(12'hfee, 32'h11, 2'h0);
    axi_wr(12'hfef, 32'h22, 2'h0);
    core_u.issue(pcrs_pkg::OP_RETURN, 11'h0, 8'h0);
    chk({pc, sp}, {15'h2211, 5'h02});
    axi_wr(12'hfed, 32'hf, 2'h0);
    core_u.issue(pcrs_pkg::OP_CALL_ABS, 11'h0, 8'h0);
    chk({pc, sp}, {15'h7800, 5'h00});
    axi_rd(12'hfee, 32'h12, 2'h0);
    axi_rd(12'hff1, 32'h1, 2'h0);
    axi_wr(12'hff2, 32'h0, 2'h0);
    chk(irq, 1'h0);
    axi_wr(12'hff2, 32'h3, 2'h0);
    @(posedge clk);
    #1;
    chk(irq, 1'h1);
    axi_wr(12'hff1, 32'h1, 2'h0);
    @(posedge clk);
    #1;
    chk(irq, 1'h0);
    axi_wr(12'hfed, 32'h1f, 2'h0);
    core_u.issue(pcrs_pkg::OP_RETURN, 11'h0, 8'h0);
    chk(sp, 5'h0e);
    axi_rd(12'hff1, 32'h2, 2'h0);
    core_u.set_option(1'h1);
    axi_wr(12'hfed, 32'hf, 2'h0);
    core_u.issue(pcrs_pkg::OP_CALL_W, 11'h0, 8'h0);
    chk({dev_rst, pc, sp}, {1'h1, 15'h0, 5'h1f});
    axi_rd(12'hff1, 32'h3, 2'h0);
    core_u.set_option(1'h0);
    axi_rd(12'h100, 32'h0, 2'h2);
    core_u.issue(pcrs_pkg::OP_INT_ENTRY, 11'h0, 8'h0);
    chk({pc, sp}, {15'h0004, 5'h00});
    axi_rd(12'hfe4, 32'h5, 2'h0);
    axi_rd(12'hfe5, 32'ha7, 2'h0);
    axi_rd(12'hfe6, 32'h13, 2'h0);
    axi_wr(12'hfe5, 32'h99, 2'h0);
    axi_rd(12'hfe7, 32'h7a, 2'h0);
    axi_rd(12'hfe9, 32'h2, 2'h0);
    axi_wr(12'hfe7, 32'h15, 2'h0);
    core_u.issue(pcrs_pkg::OP_RETURN_INT, 11'h0, 8'h0);
    chk({restore, ctx_out.wreg, ctx_out.bank}, {1'h1, 8'h99, 5'h13});
    chk(ctx_out[47:16], {3'h5, 8'h99, 5'h13, 8'h01, 8'h02});
    chk(ctx_out[15:0], 16'h0304);
    chk(latch, 7'h15);
    chk({pc, sp}, {15'h0, 5'h1f});
    final_report();
  end
endmodule
